// ---- src/pmg_map.svh ----
// register offsets, write masks, field positions and timing figures
// assumes: included by bare name from package and modules
`ifndef PMG_MAP_SVH
`define PMG_MAP_SVH

// register offsets (byte addresses on the host register port)
`define PMG_ADDR_W 9
`define PMG_OFS_DEBOUNCE 9'h010
`define PMG_OFS_ACTIONS 9'h013
`define PMG_OFS_LP_DIS 9'h014
`define PMG_OFS_PIN01 9'h015
`define PMG_OFS_PIN23 9'h016
`define PMG_OFS_PIN4 9'h017
`define PMG_OFS_WAKE_SENS 9'h01c
`define PMG_OFS_MODE_BITS 9'h01d
`define PMG_OFS_OUT_LOW 9'h01e
`define PMG_OFS_OUT_HIGH 9'h01f
`define PMG_OFS_BUCK1 9'h021
`define PMG_OFS_BUCK3 9'h022

// writable bits per register, reserved bits read zero
`define PMG_MASK_DEBOUNCE 8'h07
`define PMG_MASK_LP_DIS 8'h95
`define PMG_MASK_PIN4 8'h0f
`define PMG_MASK_FIVE 8'h1f
`define PMG_MASK_BUCK1 8'h6f
`define PMG_MASK_BUCK3 8'h7f
`define PMG_RESET_VALUE 8'h00

// action bits
`define PMG_BIT_WAKE 2
`define PMG_BIT_SHUTDOWN 1
`define PMG_BIT_KICK 0
// low-power disable bits
`define PMG_BIT_DOMAIN_DIS 7
`define PMG_BIT_CAL_FREEZE 4
`define PMG_BIT_HOST_DIS 2
`define PMG_BIT_EVENT_DIS 0
// pin config nibble: inhibit 3, polarity 2, function 1:0
`define PMG_BIT_INHIBIT 3
`define PMG_BIT_POLARITY 2
// first buck fields
`define PMG_BUCK_VSRC_HI 6
`define PMG_BUCK_VSRC_LO 5
`define PMG_BIT_BUCK_DEFAULT 3
`define PMG_BUCK_ESRC_HI 2
`define PMG_BUCK_ESRC_LO 1
`define PMG_BIT_BUCK_ON 0

// pin function codes
`define PMG_FUNC_ALT 2'h0
`define PMG_FUNC_INPUT 2'h1
`define PMG_FUNC_OPEN_DRAIN 2'h2
`define PMG_FUNC_PUSH_PULL 2'h3
// output source codes
`define PMG_SRC_STATIC 3'h0
`define PMG_SRC_FAULT 3'h1
`define PMG_SRC_SEQ 3'h3

// debounce times in microseconds and clock rate
`define PMG_CLK_MHZ 20
`define PMG_DEB1_US 100
`define PMG_DEB2_US 1000
`define PMG_DEB3_US 10240
`define PMG_DEB4_US 51200
`define PMG_DEB5_US 256000
`define PMG_DEB6_US 512000
`define PMG_DEB7_US 1024000
`define PMG_DEB_CNT_W 25

`endif

// ---- src/pmg_pkg.sv ----
// types shared by the pin control block and its debouncer
// assumes: pmg_map.svh on the include path
`include "pmg_map.svh"

package pmg_pkg;

  typedef logic [4:0] pmg_pins_type;
  typedef logic [`PMG_DEB_CNT_W-1:0] pmg_count_type;

  // debouncer state
  typedef struct packed {
    pmg_pins_type stable;
    pmg_count_type [4:0] cnt;
  } pmg_deb_state_type;

  // top state
  typedef struct packed {
    logic [7:0] lp_dis;
    logic [7:0] pin01;
    logic [7:0] pin23;
    logic [7:0] pin4;
    logic [7:0] wake_sens;
    logic [7:0] mode_bits;
    logic [7:0] out_low;
    logic [7:0] out_high;
    logic [7:0] buck1;
    logic [7:0] buck3;
    logic [2:0] debounce;
    logic [7:0] rdata;
    pmg_pins_type sync1;
    pmg_pins_type sync2;
    pmg_pins_type act_prev;
    logic vsel_a;
    logic wake;
    logic shutdown;
    logic kick;
    pmg_pins_type event_pulse;
    logic power_domain_en;
    logic system_domain_en;
    logic cal_freeze;
    logic host_off;
    logic buck_on;
    logic buck_vsel_a;
    pmg_pins_type pin_out;
    pmg_pins_type pin_oe;
  } pmg_state_type;

endpackage : pmg_pkg

// ---- src/pmg_deb_if.sv ----
// carrier between the pin control block and its debouncer
// assumes: one clock shared by both ends
`timescale 1ns/1ps
`default_nettype none

interface pmg_deb_if;
  import pmg_pkg::*;
  pmg_count_type limit;
  pmg_pins_type enable;
  pmg_pins_type raw;
  pmg_pins_type filtered;
  modport ctl (output limit, output enable, output raw, input filtered);
  modport flt (input limit, input enable, input raw, output filtered);
endinterface : pmg_deb_if

`default_nettype wire

// ---- src/pmg_debounce.sv ----
// per-pin debounce filter with a shared hold time
// assumes: raw inputs already synchronised to i_ref_clk
`timescale 1ns/1ps
`default_nettype none

module pmg_debounce
  import pmg_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  pmg_deb_if.flt deb
);

  pmg_deb_state_type state_reg;
  pmg_deb_state_type state_next;

  // ----------------------------------------------------------------
  // filter
  // ----------------------------------------------------------------
  // an enabled pin changes only after holding its new level for the full count; a disabled pin or a zero count passes the raw level straight through
  always_comb begin
    state_next = state_reg;
    for (int p = 0; p < 5; p++) begin
      if (!deb.enable[p] || deb.limit == '0) begin
        state_next.stable[p] = deb.raw[p];
        state_next.cnt[p] = '0;
      end else if (deb.raw[p] == state_reg.stable[p]) begin
        state_next.cnt[p] = '0;
      end else if (state_reg.cnt[p] + 1'b1 >= deb.limit) begin
        state_next.stable[p] = deb.raw[p];
        state_next.cnt[p] = '0;
      end else begin
        state_next.cnt[p] = state_reg.cnt[p] + 1'b1;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      // filtered level starts high like an idle pulled-up pin
      state_reg <= '{stable: 5'h1f, default: '0};
    end else begin
      state_reg <= state_next;
    end
  end

  // one buffer per pin onto the carrier
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_out
      assign deb.filtered[g] = state_reg.stable[g];
    end
  endgenerate

endmodule : pmg_debounce

`default_nettype wire

// ---- src/pmg_gpio_top.sv ----
// five-pin general-purpose block of the power manager with wakeup,
// low-power options, system action bits and first buck pin control
// assumes: register port driven by the two-wire host engine on
// i_ref_clk; sequencer and fault flag are logic on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "pmg_map.svh"

module pmg_gpio_top
  import pmg_pkg::*;
#(
  parameter int unsigned DEB_CYC_1 = `PMG_DEB1_US * `PMG_CLK_MHZ,
  parameter int unsigned DEB_CYC_2 = `PMG_DEB2_US * `PMG_CLK_MHZ,
  parameter int unsigned DEB_CYC_3 = `PMG_DEB3_US * `PMG_CLK_MHZ,
  parameter int unsigned DEB_CYC_4 = `PMG_DEB4_US * `PMG_CLK_MHZ,
  parameter int unsigned DEB_CYC_5 = `PMG_DEB5_US * `PMG_CLK_MHZ,
  parameter int unsigned DEB_CYC_6 = `PMG_DEB6_US * `PMG_CLK_MHZ,
  parameter int unsigned DEB_CYC_7 = `PMG_DEB7_US * `PMG_CLK_MHZ
) (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_reg_wr,
  input wire logic [`PMG_ADDR_W-1:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  input wire logic [4:0] i_pin_in,
  output logic [4:0] o_pin_out,
  output logic [4:0] o_pin_oe,
  input wire logic i_deep_low_power,
  input wire logic i_supply_fault,
  input wire logic [4:0] i_seq_pin,
  input wire logic i_seq_buck_vsel_a,
  output logic o_wakeup_req,
  output logic o_shutdown_req,
  output logic o_watchdog_kick,
  output logic [4:0] o_input_pin_event,
  output logic o_power_domain_en,
  output logic o_system_domain_en,
  output logic o_calendar_freeze,
  output logic o_host_bus_off,
  output logic o_first_buck_on,
  output logic o_first_buck_vsel_a,
  output logic o_first_buck_default_supply
);

  pmg_state_type state_reg;
  pmg_state_type state_next;
  pmg_deb_if deb ();

  // ----------------------------------------------------------------
  // field decoders
  // ----------------------------------------------------------------
  // config nibble of pin p: {inhibit, polarity, function}
  function automatic logic [3:0] pin_nibble(input pmg_state_type s,
                                            input int p);
    logic [3:0] r;
    r = 4'h0;
    case (p)
      0: r = s.pin01[3:0];
      1: r = s.pin01[7:4];
      2: r = s.pin23[3:0];
      3: r = s.pin23[7:4];
      default: r = s.pin4[3:0];
    endcase
    return r;
  endfunction : pin_nibble

  // output source of pin p widened to three bits
  function automatic logic [2:0] pin_src(input pmg_state_type s,
                                         input int p);
    logic [2:0] r;
    r = 3'h0;
    case (p)
      0: r = s.out_low[2:0];
      1: r = s.out_low[5:3];
      2: r = {1'b0, s.out_low[7:6]};
      3: r = s.out_high[2:0];
      default: r = {1'b0, s.out_high[4:3]};
    endcase
    return r;
  endfunction : pin_src

  // debounce code to cycle count
  function automatic pmg_count_type deb_limit(input logic [2:0] code);
    pmg_count_type r;
    r = '0;
    case (code)
      3'h1: r = DEB_CYC_1[`PMG_DEB_CNT_W-1:0];
      3'h2: r = DEB_CYC_2[`PMG_DEB_CNT_W-1:0];
      3'h3: r = DEB_CYC_3[`PMG_DEB_CNT_W-1:0];
      3'h4: r = DEB_CYC_4[`PMG_DEB_CNT_W-1:0];
      3'h5: r = DEB_CYC_5[`PMG_DEB_CNT_W-1:0];
      3'h6: r = DEB_CYC_6[`PMG_DEB_CNT_W-1:0];
      3'h7: r = DEB_CYC_7[`PMG_DEB_CNT_W-1:0];
      default: r = '0;
    endcase
    return r;
  endfunction : deb_limit

  // ----------------------------------------------------------------
  // debouncer hookup
  // ----------------------------------------------------------------
  logic [1:0] func [5];
  logic [4:0] pol;
  logic [4:0] inhibit;
  logic [4:0] is_input;
  logic [3:0] nib;

  // per-pin fields pulled out of a local copy of the config nibble
  always_comb begin
    nib = 4'h0;
    for (int p = 0; p < 5; p++) begin
      nib = pin_nibble(state_reg, p);
      func[p] = nib[1:0];
      pol[p] = nib[`PMG_BIT_POLARITY];
      inhibit[p] = nib[`PMG_BIT_INHIBIT];
      is_input[p] = !func[p][1];
    end
  end

  // debounce only for inputs with the mode bit set
  assign deb.raw = state_reg.sync2;
  assign deb.enable = is_input & state_reg.mode_bits[4:0];
  assign deb.limit = deb_limit(state_reg.debounce);

  pmg_debounce u_debounce (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .deb(deb.flt)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic [4:0] act;
  logic [4:0] rise;
  logic [4:0] fall;
  logic [4:0] wake_pin;
  logic [2:0] src;
  logic [1:0] idx;
  logic drive;
  logic sleep;
  logic wr_act;

  always_comb begin
    state_next = state_reg;
    sleep = i_deep_low_power;
    src = 3'h0;
    idx = 2'h0;
    drive = 1'b0;
    // two flops before the pins reach any logic
    state_next.sync1 = i_pin_in;
    state_next.sync2 = state_reg.sync1;

    // active level and transitions after the debouncer
    act = ~(deb.filtered ^ pol);
    rise = act & ~state_reg.act_prev;
    fall = ~act & state_reg.act_prev;
    state_next.act_prev = act;

    // register writes; action bits are never stored
    wr_act = i_reg_wr && (i_reg_addr == `PMG_OFS_ACTIONS);
    if (i_reg_wr) begin
      case (i_reg_addr)
        `PMG_OFS_DEBOUNCE:
          state_next.debounce = i_reg_wdata[2:0];
        `PMG_OFS_LP_DIS:
          state_next.lp_dis = i_reg_wdata & `PMG_MASK_LP_DIS;
        `PMG_OFS_PIN01: state_next.pin01 = i_reg_wdata;
        `PMG_OFS_PIN23: state_next.pin23 = i_reg_wdata;
        `PMG_OFS_PIN4:
          state_next.pin4 = i_reg_wdata & `PMG_MASK_PIN4;
        `PMG_OFS_WAKE_SENS:
          state_next.wake_sens = i_reg_wdata & `PMG_MASK_FIVE;
        `PMG_OFS_MODE_BITS:
          state_next.mode_bits = i_reg_wdata & `PMG_MASK_FIVE;
        `PMG_OFS_OUT_LOW: state_next.out_low = i_reg_wdata;
        `PMG_OFS_OUT_HIGH:
          state_next.out_high = i_reg_wdata & `PMG_MASK_FIVE;
        `PMG_OFS_BUCK1:
          state_next.buck1 = i_reg_wdata & `PMG_MASK_BUCK1;
        `PMG_OFS_BUCK3:
          state_next.buck3 = i_reg_wdata & `PMG_MASK_BUCK3;
        default: ;
      endcase
    end

    // wakeup from pins: edge or level, only while asleep
    for (int p = 0; p < 5; p++) begin
      wake_pin[p] = sleep && is_input[p] && !inhibit[p] &&
        (state_reg.wake_sens[p] ? act[p] : rise[p]);
    end
    state_next.wake = (wr_act && i_reg_wdata[`PMG_BIT_WAKE]) ||
                      (|wake_pin);
    state_next.shutdown = wr_act &&
                          i_reg_wdata[`PMG_BIT_SHUTDOWN];
    // pin zero as watchdog trigger shares the kick path
    state_next.kick = (wr_act && i_reg_wdata[`PMG_BIT_KICK]) ||
                      (func[0] == `PMG_FUNC_ALT && rise[0]);

    // input events, muted in sleep when asked
    state_next.event_pulse = (sleep &&
      state_reg.lp_dis[`PMG_BIT_EVENT_DIS]) ? 5'h00 :
      (rise & is_input);

    // domain enables from pins two and four, frozen in sleep if asked
    if (!(sleep && state_reg.lp_dis[`PMG_BIT_DOMAIN_DIS])) begin
      if (func[2] == `PMG_FUNC_ALT) begin
        state_next.power_domain_en = act[2];
      end
      if (func[4] == `PMG_FUNC_ALT) begin
        state_next.system_domain_en = act[4];
      end
    end
    state_next.cal_freeze = sleep &&
      state_reg.lp_dis[`PMG_BIT_CAL_FREEZE];
    state_next.host_off = sleep &&
      state_reg.lp_dis[`PMG_BIT_HOST_DIS];

    // first buck enable: selected input edges rewrite the enable bit;
    // hardware edge wins over a write in the same cycle
    idx = state_next.buck1[`PMG_BUCK_ESRC_HI:`PMG_BUCK_ESRC_LO];
    if (idx != 2'h0 && func[idx] == `PMG_FUNC_INPUT) begin
      if (rise[idx]) begin
        state_next.buck1[`PMG_BIT_BUCK_ON] = 1'b1;
      end else if (fall[idx]) begin
        state_next.buck1[`PMG_BIT_BUCK_ON] = 1'b0;
      end
    end
    state_next.buck_on = state_next.buck1[`PMG_BIT_BUCK_ON];

    // first buck voltage select
    idx = state_reg.buck1[`PMG_BUCK_VSRC_HI:`PMG_BUCK_VSRC_LO];
    if (idx != 2'h0 && func[idx] == `PMG_FUNC_INPUT) begin
      if (rise[idx]) begin
        state_next.vsel_a = 1'b1;
      end else if (fall[idx]) begin
        state_next.vsel_a = 1'b0;
      end
    end
    state_next.buck_vsel_a = (idx == 2'h0) ? i_seq_buck_vsel_a :
                             state_next.vsel_a;

    // output drivers; reserved sources drive the passive level
    for (int p = 0; p < 5; p++) begin
      src = pin_src(state_reg, p);
      idx = src[1:0];
      if (p == 2 && func[p] == `PMG_FUNC_PUSH_PULL) begin
        src = `PMG_SRC_FAULT;
      end
      case (src)
        `PMG_SRC_STATIC: drive = 1'b1;
        `PMG_SRC_FAULT: drive = i_supply_fault;
        `PMG_SRC_SEQ: drive = i_seq_pin[p];
        3'h4, 3'h5, 3'h6, 3'h7:
          // a pin never forwards itself, that code is reserved
          drive = (int'(idx) != p) && act[idx];
        default: drive = 1'b0;
      endcase
      // static drives the mode bit, others apply it as polarity
      if (src == `PMG_SRC_STATIC) begin
        drive = state_reg.mode_bits[p];
      end else begin
        drive = state_reg.mode_bits[p] ? drive : !drive;
      end
      case (func[p])
        `PMG_FUNC_OPEN_DRAIN: begin
          state_next.pin_out[p] = 1'b0;
          state_next.pin_oe[p] = !drive;
        end
        `PMG_FUNC_PUSH_PULL: begin
          state_next.pin_out[p] = drive;
          state_next.pin_oe[p] = 1'b1;
        end
        default: begin
          state_next.pin_out[p] = 1'b0;
          state_next.pin_oe[p] = 1'b0;
        end
      endcase
    end

    // readback, one cycle after the address
    case (i_reg_addr)
      `PMG_OFS_DEBOUNCE: state_next.rdata = {5'h00, state_reg.debounce};
      `PMG_OFS_ACTIONS: state_next.rdata = 8'h00;
      `PMG_OFS_LP_DIS: state_next.rdata = state_reg.lp_dis;
      `PMG_OFS_PIN01: state_next.rdata = state_reg.pin01;
      `PMG_OFS_PIN23: state_next.rdata = state_reg.pin23;
      `PMG_OFS_PIN4: state_next.rdata = state_reg.pin4;
      `PMG_OFS_WAKE_SENS: state_next.rdata = state_reg.wake_sens;
      `PMG_OFS_MODE_BITS: state_next.rdata = state_reg.mode_bits;
      `PMG_OFS_OUT_LOW: state_next.rdata = state_reg.out_low;
      `PMG_OFS_OUT_HIGH: state_next.rdata = state_reg.out_high;
      `PMG_OFS_BUCK1: state_next.rdata = state_reg.buck1;
      `PMG_OFS_BUCK3: state_next.rdata = state_reg.buck3;
      default: state_next.rdata = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      // synchronisers start at the pull-up level: no false edge after reset
      state_reg <= '{sync1: 5'h1f, sync2: 5'h1f, default: '0};
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs straight from flops
  assign o_reg_rdata = state_reg.rdata;
  assign o_pin_out = state_reg.pin_out;
  assign o_pin_oe = state_reg.pin_oe;
  assign o_wakeup_req = state_reg.wake;
  assign o_shutdown_req = state_reg.shutdown;
  assign o_watchdog_kick = state_reg.kick;
  assign o_input_pin_event = state_reg.event_pulse;
  assign o_power_domain_en = state_reg.power_domain_en;
  assign o_system_domain_en = state_reg.system_domain_en;
  assign o_calendar_freeze = state_reg.cal_freeze;
  assign o_host_bus_off = state_reg.host_off;
  assign o_first_buck_on = state_reg.buck_on;
  assign o_first_buck_vsel_a = state_reg.buck_vsel_a;
  assign o_first_buck_default_supply =
    state_reg.buck1[`PMG_BIT_BUCK_DEFAULT];

endmodule : pmg_gpio_top

`default_nettype wire

// ---- sim/pmg_gpio_top_sva.sv ----
// checker for the pin control block: action pulses and sleep levels
// assumes: bound to pmg_gpio_top, one clock, sync active-low reset
`timescale 1ns/1ps
`default_nettype none
`include "pmg_map.svh"

module pmg_gpio_top_chk (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_reg_wr,
  input wire logic [`PMG_ADDR_W-1:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  input wire logic i_deep_low_power,
  input wire logic o_wakeup_req,
  input wire logic o_shutdown_req,
  input wire logic o_watchdog_kick,
  input wire logic o_calendar_freeze,
  input wire logic o_host_bus_off,
  input wire logic o_first_buck_on
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rstn);

  // ----------------------------------------
  // decoded register writes
  // ----------------------------------------
  logic act_wr;
  logic shut_wr;
  logic kick_wr;
  logic buck_wr;
  assign act_wr = i_reg_wr && (i_reg_addr == `PMG_OFS_ACTIONS);
  assign shut_wr = act_wr && i_reg_wdata[`PMG_BIT_SHUTDOWN];
  assign kick_wr = act_wr && i_reg_wdata[`PMG_BIT_KICK];
  // written enable bit checked only when no source pin is selected
  assign buck_wr = i_reg_wr && (i_reg_addr == `PMG_OFS_BUCK1) &&
                   (i_reg_wdata[2:1] == 2'h0);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  chk_wake_pulse: assert property (
    act_wr && i_reg_wdata[`PMG_BIT_WAKE] |=> o_wakeup_req)
    else $error("wake request missing after write");
  chk_shut_single: assert property (
    shut_wr ##1 !shut_wr |-> o_shutdown_req ##1 !o_shutdown_req)
    else $error("shutdown request not a single pulse");
  chk_shut_cause: assert property (
    o_shutdown_req |-> $past(shut_wr))
    else $error("shutdown request without a write");
  chk_kick_pulse: assert property (
    kick_wr |=> o_watchdog_kick)
    else $error("watchdog kick missing after write");
  chk_action_zero: assert property (
    i_reg_addr == `PMG_OFS_ACTIONS |=> o_reg_rdata == 8'h00)
    else $error("action register read not zero");
  chk_freeze_awake: assert property (
    !i_deep_low_power |=> !o_calendar_freeze)
    else $error("calendar frozen while awake");
  chk_host_awake: assert property (
    !i_deep_low_power [*2] |=> !o_host_bus_off)
    else $error("host bus off while awake");
  chk_buck_bit: assert property (
    buck_wr |=> o_first_buck_on == $past(i_reg_wdata[0]))
    else $error("buck enable differs from written bit");
endmodule : pmg_gpio_top_chk

bind pmg_gpio_top pmg_gpio_top_chk chk_u (.i_ref_clk, .i_rstn,
  .i_reg_wr, .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .i_deep_low_power,
  .o_wakeup_req, .o_shutdown_req, .o_watchdog_kick, .o_calendar_freeze,
  .o_host_bus_off, .o_first_buck_on);

`default_nettype wire

// ---- sim/pmg_pin_model.sv ----
// far-side pin logic: external drivers with a pull-up on released pins
// assumes: values set by the bench, level feeds the block's pin inputs
`timescale 1ns/1ps
`default_nettype none

module pmg_pin_model (
  input wire logic [4:0] i_pin_out,
  input wire logic [4:0] i_pin_oe,
  input wire logic [4:0] i_ext_val,
  input wire logic [4:0] i_ext_en,
  output logic [4:0] o_pin_level
);
  // block drive wins, so no contention is modelled; released pins rise
  always_comb begin
    for (int k = 0; k < 5; k++) begin
      o_pin_level[k] = i_pin_oe[k] ? i_pin_out[k] :
                       (i_ext_en[k] ? i_ext_val[k] : 1'b1);
    end
  end
endmodule : pmg_pin_model

`default_nettype wire

// ---- sim/pmg_gpio_top_bench.sv ----
// register-level bench for the pin control block
// assumes: pin model on the pins, debounce counts shortened
`timescale 1ns/1ps
`default_nettype none
`include "pmg_map.svh"

module pmg_gpio_top_bench;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic wr = 1'b0;
  logic [8:0] addr = 9'h000;
  logic [7:0] wd = 8'h00;
  logic [7:0] rd;
  logic [4:0] pin, pout, poe, ev;
  logic [4:0] ext = 5'h00;
  logic [4:0] ext_on = 5'h1f;
  logic seqv = 1'b0;
  logic [4:0] seq = 5'h00;
  logic sleep = 1'b0;
  logic fault = 1'b0;
  logic wake, shut, kick, pden, sden, calf, hoff, bon, bva, bdef;
  int fail_count = 0;
  int total_checks = 0;
  int wcnt, ecnt;
  logic [8:0] ofs [13] = '{9'h010, 9'h013, 9'h014, 9'h015, 9'h016,
    9'h017, 9'h01c, 9'h01d, 9'h01e, 9'h01f, 9'h021, 9'h022, 9'h018};
  logic [7:0] msk [13] = '{8'h07, 8'h00, 8'h95, 8'hff, 8'hff, 8'h0f,
    8'h1f, 8'h1f, 8'hff, 8'h1f, 8'h6f, 8'h7f, 8'h00};

  // 20 MHz clock
  always #25 clk = ~clk;

  // codes six and seven keep full length; no debounced pin sees them
  pmg_gpio_top #(.DEB_CYC_1(2), .DEB_CYC_2(4), .DEB_CYC_3(6),
    .DEB_CYC_4(8), .DEB_CYC_5(10))
  dut_u (.i_ref_clk(clk), .i_rstn(rstn), .i_reg_wr(wr), .i_reg_addr(addr),
    .i_reg_wdata(wd), .o_reg_rdata(rd), .i_pin_in(pin), .o_pin_out(pout),
    .o_pin_oe(poe), .i_deep_low_power(sleep), .i_supply_fault(fault),
    .i_seq_pin(seq), .i_seq_buck_vsel_a(seqv), .o_wakeup_req(wake),
    .o_shutdown_req(shut), .o_watchdog_kick(kick), .o_input_pin_event(ev),
    .o_power_domain_en(pden), .o_system_domain_en(sden),
    .o_calendar_freeze(calf), .o_host_bus_off(hoff),
    .o_first_buck_on(bon), .o_first_buck_vsel_a(bva),
    .o_first_buck_default_supply(bdef));

  pmg_pin_model pins_u (.i_pin_out(pout), .i_pin_oe(poe), .i_ext_val(ext),
    .i_ext_en(ext_on), .o_pin_level(pin));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // inputs always move 1 ns after an edge; any pending write ends here
  task automatic step(input int n);
    wr = 1'b0;
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  // strobe stays up after its edge so back-to-back writes never glitch
  task automatic wr_reg(input logic [8:0] a, input logic [7:0] d);
    wr = 1'b1;
    addr = a;
    wd = d;
    @(posedge clk);
    #1;
  endtask : wr_reg

  task automatic rd_reg(input logic [8:0] a, input logic [7:0] exp);
    addr = a;
    step(1);
    check(rd, exp);
  endtask : rd_reg

  // counts wake and event pulses over a window
  task automatic watch(input int n);
    wcnt = 0;
    ecnt = 0;
    repeat (n) begin
      step(1);
      wcnt += int'(wake);
      ecnt += int'(|ev);
    end
  endtask : watch

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    step(16);
    rstn = 1'b1;
    step(2);
    foreach (ofs[k]) rd_reg(ofs[k], 8'h00);
    foreach (ofs[k]) begin
      wr_reg(ofs[k], 8'hff);
      rd_reg(ofs[k], msk[k]);
      wr_reg(ofs[k], 8'h00);
    end
    $display("test registers done");
    wr_reg(`PMG_OFS_ACTIONS, 8'h07);
    check({5'h0, wake, shut, kick}, 8'h07);
    step(1);
    check({5'h0, wake, shut, kick}, 8'h00);
    wr_reg(`PMG_OFS_LP_DIS, 8'h14);
    step(2);
    check({6'h0, calf, hoff}, 8'h00);
    sleep = 1'b1;
    step(2);
    check({6'h0, calf, hoff}, 8'h03);
    sleep = 1'b0;
    wr_reg(`PMG_OFS_LP_DIS, 8'h00);
    $display("test actions done");
    // pin zero push-pull then open-drain, static mode bit one
    wr_reg(`PMG_OFS_PIN01, 8'h53);
    wr_reg(`PMG_OFS_MODE_BITS, 8'h01);
    step(1);
    check({6'h0, poe[0], pout[0]}, 8'h03);
    wr_reg(`PMG_OFS_PIN01, 8'h52);
    step(1);
    check({6'h0, poe[0], pout[0]}, 8'h00);
    wr_reg(`PMG_OFS_PIN01, 8'h53);
    wr_reg(`PMG_OFS_OUT_LOW, 8'h01);
    fault = 1'b1;
    step(2);
    check({7'h0, pout[0]}, 8'h01);
    fault = 1'b0;
    wr_reg(`PMG_OFS_OUT_LOW, 8'h05);
    ext_on[1] = 1'b0; // released pin rises to the pull-up
    step(6);
    check({7'h0, pout[0]}, 8'h01);
    ext_on[1] = 1'b1;
    step(6);
    check({7'h0, pout[0]}, 8'h00);
    wr_reg(`PMG_OFS_PIN4, 8'h03);
    wr_reg(`PMG_OFS_OUT_HIGH, 8'h18);
    wr_reg(`PMG_OFS_MODE_BITS, 8'h10);
    seq = 5'h10;
    step(2);
    check({6'h0, poe[4], pout[4]}, 8'h03);
    $display("test outputs done");
    // pin three wakeup, inhibit, then event disable, in sleep
    wr_reg(`PMG_OFS_PIN23, 8'h50);
    sleep = 1'b1;
    step(6);
    check({6'h0, pden, sden}, 8'h03);
    ext[3] = 1'b1;
    watch(8);
    check(8'(wcnt), 8'h01);
    check(8'(ecnt), 8'h01);
    ext[3] = 1'b0;
    wr_reg(`PMG_OFS_PIN23, 8'hd0);
    step(6);
    ext[3] = 1'b1;
    watch(8);
    check(8'(wcnt), 8'h00);
    ext[3] = 1'b0;
    wr_reg(`PMG_OFS_LP_DIS, 8'h81);
    step(6);
    ext[3] = 1'b1;
    ext[2] = 1'b1;
    watch(8);
    check(8'(ecnt), 8'h00);
    check({7'h0, pden}, 8'h01);
    sleep = 1'b0;
    wr_reg(`PMG_OFS_LP_DIS, 8'h00);
    $display("test wakeup done");
    // pin one drives first buck enable and voltage select
    wr_reg(`PMG_OFS_PIN01, 8'h50);
    wr_reg(`PMG_OFS_BUCK1, 8'h22);
    step(6);
    check({7'h0, pden}, 8'h00);
    ext[1] = 1'b1;
    step(6);
    check({6'h0, bva, bon}, 8'h03);
    ext[1] = 1'b0;
    step(6);
    check({6'h0, bva, bon}, 8'h00);
    // pin one must hold six cycles before the buck follows it
    wr_reg(`PMG_OFS_DEBOUNCE, 8'h03);
    wr_reg(`PMG_OFS_MODE_BITS, 8'h12);
    ext[1] = 1'b1;
    step(7);
    check({7'h0, bon}, 8'h00);
    step(3);
    check({7'h0, bon}, 8'h01);
    // voltage select handed back to the sequencer
    seqv = 1'b1;
    wr_reg(`PMG_OFS_BUCK1, 8'h08);
    step(1);
    check({5'h0, bdef, bva, bon}, 8'h06);
    seqv = 1'b0;
    step(2);
    check({7'h0, bva}, 8'h00);
    $display("test buck done");
    end_of_test();
  end

  // cuts a hang short well past the expected run length
  initial begin
    #(50 * 4000);
    fail_count++;
    end_of_test();
  end
endmodule : pmg_gpio_top_bench

`default_nettype wire
